// file: hdl/mfe_top.sv
// Motion feature engine top: config block, status flags, step logic
`timescale 1ns/1ns
`default_nettype none
module mfe_top #(
	parameter int TICK_CYCLES = mfe_pkg::FEAT_TICK_CYCLES
) (
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	// Config block burst port
	input wire logic cfg_start_in,
	input wire logic cfg_wr_in,
	input wire logic cfg_rd_in,
	input wire logic [7:0] cfg_wdata_in,
	output logic [7:0] cfg_rdata_out,
	// Control bits
	input wire logic cont_mode_in,
	input wire logic [11:0] odr_hz_in,
	input wire logic count_en_in,
	input wire logic detect_en_in,
	input wire logic activity_en_in,
	input wire logic tap_en_in,
	input wire logic [9:0] thresh_in,
	input wire logic clear_req_in,
	input wire logic [5:0] remap_in,
	input wire logic [2:0] remap_sign_in,
	input wire logic [4:0] coef_sel_in,
	input wire logic coef_wr_in,
	input wire logic [15:0] coef_in,
	input wire logic fatal_in,
	// Sample input and detected features
	input wire logic sample_valid_in,
	input wire logic [47:0] sample_in,
	input wire logic step_det_in,
	input wire logic act_change_in,
	input wire logic tilt_in,
	input wire logic tap_in,
	input wire logic motion_in,
	input wire logic status_clr_in,
	// Outputs
	output logic [7:0] int_status_out,
	output logic [7:0] health_out,
	output logic [31:0] step_count_out,
	output logic clear_pending_out,
	output logic activity_run_out,
	output logic feat_tick_out,
	output logic [47:0] feat_sample_out,
	output logic [47:0] raw_sample_out,
	output logic [15:0] coef_active_out
);
	typedef struct packed {
		mfe_pkg::mfe_state_t state;
		logic [5:0] cfg_ptr;
		logic [7:0] cfg_q;
		logic [7:0] status;
		logic [7:0] health;
		logic clear_pend;
		logic [31:0] tick_cnt;
		logic tick;
		logic [47:0] feat;
		logic [47:0] raw;
		logic en_q;
		logic [15:0] coef_q;
	} mfe_top_t;
	mfe_top_t st, next_st;
	logic [7:0] cfg_mem [mfe_pkg::CFG_BYTES];
	logic [15:0] coef_shadow [mfe_pkg::NUM_COEF];
	logic [15:0] coef_live [mfe_pkg::NUM_COEF];
	logic [31:0] count;
	logic hit;
	logic step_en;
	logic run;
	logic [47:0] mapped;

	mfe_axis_if ax ();
	assign ax.raw = sample_in;
	assign ax.remap_cfg = {remap_sign_in, remap_in}; // [R10]
	assign mapped = ax.mapped;

	mfe_remap u_remap (
		.ax(ax)
	);

	assign step_en = count_en_in | detect_en_in;
	assign run = (st.state == mfe_pkg::MFE_RUN);

	mfe_engine u_eng (
		.core_clk_in(core_clk_in),
		.reset_n_in(reset_n_in),
		.run_in(run && count_en_in), // [R13]
		.step_in(step_det_in),
		.thresh_in(thresh_in),
		.clear_in(st.clear_pend && count_en_in), // [R22]
		.count_out(count),
		.thresh_hit_out(hit)
	);

	////////////////////////////////////////////////////////////////////////
	// State update
	always_comb begin
		next_st = st;
		// Burst pointer walks configuration bytes in order
		if (cfg_start_in)
			next_st.cfg_ptr = 6'h00; // [R2]
		else if (cfg_wr_in || cfg_rd_in)
			next_st.cfg_ptr = (st.cfg_ptr == mfe_pkg::CFG_LAST) ? 6'h00 : st.cfg_ptr + 6'h1; // [R2]
		if (cfg_rd_in)
			next_st.cfg_q = cfg_mem[st.cfg_ptr];
		// Fixed-rate feature tick
		next_st.tick = 1'b0;
		if (st.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
			next_st.tick_cnt = 32'h0;
			next_st.tick = run; // [R6]
		end else begin
			next_st.tick_cnt = st.tick_cnt + 32'h1;
		end
		// Remapped samples feed the engine, raw copy kept apart
		if (sample_valid_in) begin
			next_st.feat = mapped; // [R10] [R11]
			next_st.raw = sample_in; // [R11]
		end
		// Engine state
		case (st.state)
			mfe_pkg::MFE_IDLE: next_st.state = mfe_pkg::MFE_RUN;
			mfe_pkg::MFE_RUN: if (fatal_in) next_st.state = mfe_pkg::MFE_HALT; // [R5]
			mfe_pkg::MFE_HALT: next_st.state = mfe_pkg::MFE_HALT;
			default: next_st.state = mfe_pkg::MFE_IDLE;
		endcase
		// Self-clearing count clear
		if (st.clear_pend)
			next_st.clear_pend = 1'b0; // [R14]
		if (clear_req_in && count_en_in)
			next_st.clear_pend = 1'b1; // [R22]
		// Status flags, set wins over clear
		if (status_clr_in)
			next_st.status = mfe_pkg::STATUS_RESET;
		if (run) begin
			if ((thresh_in == 10'h0) ? (detect_en_in && step_det_in) : hit)
				next_st.status[0] = 1'b1; // [R12] [R17] [R21]
			if (act_change_in && activity_en_in && count_en_in)
				next_st.status[1] = 1'b1; // [R4] [R23]
			if (tilt_in)
				next_st.status[2] = 1'b1; // [R4]
			if (tap_in)
				next_st.status[3] = 1'b1; // [R4]
			if (motion_in)
				next_st.status[4] = 1'b1; // [R4]
		end
		if (fatal_in || st.state == mfe_pkg::MFE_HALT)
			next_st.status[7] = 1'b1; // [R5]
		// Low-power output rate checks
		next_st.health = 8'h00;
		if (!cont_mode_in) begin // [R7]
			next_st.health[0] = (odr_hz_in < 12'(mfe_pkg::MIN_ODR_HZ)); // [R9]
			next_st.health[1] = tap_en_in && (odr_hz_in < 12'(mfe_pkg::MIN_ODR_TAP_HZ)); // [R9]
		end
		// Coefficients become live on re-enable
		next_st.en_q = step_en;
		next_st.coef_q = coef_live[coef_sel_in < 5'd25 ? coef_sel_in : 5'd0];
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in)
			st <= '0;
		else
			st <= next_st;
	end

	// Config memory burst write
	always_ff @(posedge core_clk_in) begin
		if (cfg_wr_in)
			cfg_mem[st.cfg_ptr] <= cfg_wdata_in; // [R2]
	end

	// Tuning coefficients: shadow written by host, live copied on enable edge
	always_ff @(posedge core_clk_in) begin
		for (int i = 0; i < mfe_pkg::NUM_COEF; i++) begin
			if (!reset_n_in) begin
				coef_shadow[i] <= mfe_pkg::WRIST_COEF[i]; // [R18]
				coef_live[i] <= mfe_pkg::WRIST_COEF[i]; // [R18]
			end else begin
				if (coef_wr_in && coef_sel_in == 5'(i))
					coef_shadow[i] <= coef_in;
				if (step_en && !st.en_q)
					coef_live[i] <= coef_shadow[i]; // [R20]
			end
		end
	end

	assign cfg_rdata_out = st.cfg_q;
	assign int_status_out = st.status;
	assign health_out = st.health;
	assign step_count_out = count;
	assign clear_pending_out = st.clear_pend;
	assign activity_run_out = activity_en_in && count_en_in && run; // [R23]
	assign feat_tick_out = st.tick;
	assign feat_sample_out = st.feat;
	assign raw_sample_out = st.raw;
	assign coef_active_out = st.coef_q;
endmodule
`default_nettype wire

// file: shared/mfe_pkg.sv
// Package of constants and types for the motion feature engine step counter
// Summary of operation
// [R1] Host changes settings by reading, editing and rewriting the whole config block.
// [R2] Burst bytes map in order onto configuration bytes 0x00 to 0x3F.
// [R3] Host initialises the device before any configuration access.
// [R4] Each feature output has its own status flag, including fatal error.
// [R5] Fatal error stops the engine and raises its flag; host reinitialises.
// [R6] Engine takes acceleration samples at a fixed 50 Hz.
// [R7] Continuous sampling: features work at any output rate and bandwidth.
// [R8] Low power: host sets at least 50 Hz, 200 Hz with tap.
// [R9] Low-power rate violation sets the matching engine health flag.
// [R10] Each feature axis picks a physical axis with an optional sign inversion.
// [R11] Remap applies only to engine input; raw sample output stays unmapped.
// [R12] Counter and detector run together; one event source drives the step flag.
// [R13] 32-bit step count exposed as four bytes, enabled by counting enable.
// [R14] Count clear zeroes the count, self-clears, counting resumes.
// [R15] Threshold scaled by 20; flag set each time count advances by that.
// [R16] Threshold event may fire up to ten steps after crossing.
// [R17] Per-step enable sets the step flag for every detected step.
// [R18] 25 tuning coefficients reset to wrist preset; host may load phone preset.
// [R19] Host disables step functions before writing coefficients, then re-enables.
// [R20] New coefficients take effect only after step functions are re-enabled.
// [R21] Threshold zero selects per-step event; range up to 20460 in steps of 20.
// [R22] Count clear is honoured only while counting is enabled.
// [R23] Activity recognition runs only with both activity and counting enabled.
// [R24] Step count wraps to zero past its 32-bit maximum.
package mfe_pkg;
	localparam int CFG_BYTES = 64;
	localparam logic [5:0] CFG_LAST = 6'h3f;
	localparam int CLK_HZ = 10000000;
	localparam int FEAT_RATE_HZ = 50;
	localparam int FEAT_TICK_CYCLES = CLK_HZ / FEAT_RATE_HZ;
	localparam int MIN_ODR_HZ = 50;
	localparam int MIN_ODR_TAP_HZ = 200;
	localparam int STEP_SCALE = 20;
	localparam int STEP_BUF_MAX = 10;
	localparam int NUM_COEF = 25;
	// Wrist preset, two's complement 16 bit
	localparam logic [15:0] WRIST_COEF [NUM_COEF] = '{
		16'h012d, 16'h7bd4, 16'h013b, 16'h7adb, 16'h0004, 16'h7b3f, 16'h6ccd,
		16'h04c3, 16'h0985, 16'h04c3, 16'he6ec, 16'h460c, 16'h0001, 16'h0027,
		16'h0019, 16'h0096, 16'h00a0, 16'h0001, 16'h000c, 16'h3cf0, 16'h0100,
		16'h0001, 16'h0003, 16'h0001, 16'h000e};
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [31:0] COUNT_RESET = 32'h00000000;
	typedef enum logic [1:0] {
		MFE_IDLE = 2'b00,
		MFE_RUN = 2'b01,
		MFE_HALT = 2'b10
	} mfe_state_t;
endpackage

// file: shared/mfe_axis_if.sv
// Interface carrying raw and remapped samples between engine modules
`timescale 1ns/1ns
`default_nettype none
interface mfe_axis_if;
	logic [47:0] raw;
	logic [47:0] mapped;
	logic [8:0] remap_cfg; // Selects in [5:0], sign bits in [8:6]
	modport src (output raw, output remap_cfg, input mapped);
	modport map (input raw, input remap_cfg, output mapped);
endinterface
`default_nettype wire

// file: hdl/mfe_remap.sv
// Axis remapper for samples entering the feature engine
`timescale 1ns/1ns
`default_nettype none
module mfe_remap (
	mfe_axis_if.map ax
);
	// Pick one physical axis per feature axis, then negate if asked
	function automatic logic [15:0] pick(input logic [47:0] s, input logic [1:0] sel,
		input logic neg);
		logic [15:0] v;
		v = (sel == 2'h1) ? s[31:16] : (sel == 2'h2) ? s[47:32] : s[15:0];
		pick = neg ? 16'(-v) : v;
	endfunction

	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_ax
			// Two select bits per axis, its sign bit above all the selects
			assign ax.mapped[16*i +: 16] = pick(ax.raw, ax.remap_cfg[2*i +: 2],
				ax.remap_cfg[6 + i]); // [R10]
		end
	endgenerate
endmodule
`default_nettype wire

// file: hdl/mfe_engine.sv
// Step counter core: count, threshold event, clear
`timescale 1ns/1ns
`default_nettype none
module mfe_engine (
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	input wire logic run_in,
	input wire logic step_in,
	input wire logic [9:0] thresh_in,
	input wire logic clear_in,
	output logic [31:0] count_out,
	output logic thresh_hit_out
);
	typedef struct packed {
		logic [31:0] count;
		logic [31:0] next_mark;
		logic hit;
	} mfe_eng_t;
	mfe_eng_t st, next_st;
	logic [31:0] span;

	// Threshold scaled by the fixed factor
	assign span = 32'(thresh_in) * 32'(mfe_pkg::STEP_SCALE); // [R15]

	// Count, wrap and threshold tracking
	always_comb begin
		next_st = st;
		next_st.hit = 1'b0;
		if (clear_in) begin
			next_st.count = mfe_pkg::COUNT_RESET; // [R14]
			next_st.next_mark = span;
		end else if (run_in && step_in) begin
			next_st.count = st.count + 32'h1; // [R24]
			if (span != 32'h0 && (st.count + 32'h1) >= st.next_mark) begin
				next_st.hit = 1'b1; // [R15] [R16]
				next_st.next_mark = st.next_mark + span;
			end
		end
		if (span == 32'h0)
			next_st.next_mark = 32'h0;
		else if (st.next_mark == 32'h0)
			next_st.next_mark = next_st.count + span;
	end

	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in)
			st <= '0;
		else
			st <= next_st;
	end

	assign count_out = st.count;
	assign thresh_hit_out = st.hit;
endmodule
`default_nettype wire

// file: sim/mfe_top_sva.sv
// Checker for the motion feature engine top ports
`timescale 1ns/1ns
`default_nettype none
module mfe_top_sva #(parameter int TICK_CYCLES = 10) (
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	input wire logic cont_mode_in,
	input wire logic [11:0] odr_hz_in,
	input wire logic count_en_in,
	input wire logic activity_en_in,
	input wire logic clear_req_in,
	input wire logic fatal_in,
	input wire logic step_det_in,
	input wire logic [7:0] int_status_out,
	input wire logic [7:0] health_out,
	input wire logic [31:0] step_count_out,
	input wire logic clear_pending_out,
	input wire logic activity_run_out,
	input wire logic feat_tick_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);
	// Clear request accepted, then pending, then zero count
	sequence s_clear_req;
		clear_req_in && count_en_in && !clear_pending_out;
	endsequence
	sequence s_clear_walk;
		clear_pending_out ##1 (step_count_out == 32'h0 && !clear_pending_out);
	endsequence
	a_clear_walk: assert property (s_clear_req |=> s_clear_walk)
		else $error("count clear sequence broken");
	a_clear_ignored: assert property (clear_req_in && !count_en_in && !clear_pending_out
		|=> !clear_pending_out) else $error("clear taken while counting off");
	// Each counted step adds one, wrapping past the top
	a_count_step: assert property (count_en_in && step_det_in && !clear_req_in
		&& !clear_pending_out && !int_status_out[7] && !fatal_in
		|=> step_count_out == $past(step_count_out) + 32'h1) else $error("step not counted");
	a_fatal_flag: assert property (fatal_in |=> int_status_out[7])
		else $error("fatal flag missing");
	a_activity_gate: assert property (activity_run_out |-> activity_en_in && count_en_in)
		else $error("activity runs without both enables");
	a_health_low: assert property (!cont_mode_in && odr_hz_in < 12'h032 |=> health_out[0])
		else $error("low rate not flagged");
	a_health_cont: assert property (cont_mode_in && $past(cont_mode_in)
		|-> health_out[1:0] == 2'b00) else $error("rate flag in continuous mode");
	a_tick_gap: assert property (feat_tick_out |=> !feat_tick_out [*8])
		else $error("sample ticks too close");
endmodule
bind mfe_top mfe_top_sva #(.TICK_CYCLES(TICK_CYCLES)) chk (.*);
`default_nettype wire

// file: sim/mfe_walker.sv
// Step source standing in for the far-side motion detection
`timescale 1ns/1ns
`default_nettype none
module mfe_walker (
	input wire logic core_clk_in,
	input wire logic [7:0] steps_in,
	input wire logic go_in,
	output logic step_out,
	output logic busy_out
);
	logic [7:0] left = 8'h00;
	initial step_out = 1'b0;
	// One-cycle step pulses with random gaps, launched on the falling edge
	always @(negedge core_clk_in) begin
		step_out <= 1'b0;
		if (go_in && left == 8'h00) begin
			left <= steps_in;
		end else if (left != 8'h00 && !step_out && $urandom_range(1) == 1) begin
			step_out <= 1'b1;
			left <= left - 8'h01;
		end
	end
	assign busy_out = (left != 8'h00) || step_out;
endmodule
`default_nettype wire

// file: sim/mfe_top_test.sv
// Self-checking testbench for the motion feature engine top
`timescale 1ns/1ns
`default_nettype none
module mfe_top_test;
	logic core_clk_in = 1'b0, reset_n_in = 1'b0, cfg_start_in = 1'b0, cfg_wr_in = 1'b0;
	logic cfg_rd_in = 1'b0, cont_mode_in = 1'b1, count_en_in = 1'b0, detect_en_in = 1'b0;
	logic activity_en_in = 1'b0, tap_en_in = 1'b0, clear_req_in = 1'b0, coef_wr_in = 1'b0;
	logic fatal_in = 1'b0, sample_valid_in = 1'b0, status_clr_in = 1'b0, go = 1'b0, peek = 1'b0;
	logic [7:0] cfg_wdata_in = 8'h00, n_steps = 8'h00, int_status_out, health_out, cfg_rdata_out;
	logic [11:0] odr_hz_in = 12'h064;
	logic [9:0] thresh_in = 10'h000;
	logic [5:0] remap_in = 6'h24;
	logic [2:0] remap_sign_in = 3'h0;
	logic [4:0] coef_sel_in = 5'h00;
	logic [15:0] coef_in = 16'h0000, coef_active_out;
	logic [47:0] sample_in = 48'h0, feat_sample_out, raw_sample_out;
	logic [31:0] step_count_out;
	logic [3:0] ev = 4'h0;
	logic step_det_in, act_change_in, tilt_in, tap_in, motion_in, busy;
	logic clear_pending_out, activity_run_out, feat_tick_out;
	logic [47:0] exp_q[$];
	logic [47:0] seen[7];
	int sel = 0, n_errors = 0, checks_done = 0, cycles = 0;
	assign {motion_in, tap_in, tilt_in, act_change_in} = ev;
	assign seen = '{cfg_rdata_out, step_count_out, int_status_out, health_out, coef_active_out,
		feat_sample_out, raw_sample_out};
	mfe_top #(.TICK_CYCLES(10)) uut (.*);
	mfe_walker walker (.core_clk_in(core_clk_in), .steps_in(n_steps), .go_in(go),
		.step_out(step_det_in), .busy_out(busy));
	always #50 core_clk_in = ~core_clk_in;
	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (n_errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input logic [47:0] got, input logic [47:0] want);
		checks_done++;
		if (got !== want) begin
			n_errors++;
			$display("Error %0t: saw %h, expected %h", $time, got, want);
		end
	endtask
	// Monitor takes the oldest note when a result is flagged
	always @(posedge core_clk_in) begin
		cycles++;
		if (peek) begin
			check(seen[sel], exp_q.pop_front());
			peek <= 1'b0;
		end
		if (cycles > 20000) begin
			n_errors++;
			stop_test();
		end
	end
	task automatic note(input int w, input logic [47:0] v);
		exp_q.push_back(v);
		sel = w;
		peek = 1'b1;
		@(negedge core_clk_in);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge core_clk_in);
		s = 1'b0;
		@(negedge core_clk_in);
	endtask
	task automatic walk(input logic [7:0] n);
		// One-cycle go so the model loads the count once, then wait until it has sent all its steps
		n_steps <= n;
		go <= 1'b1;
		@(negedge core_clk_in);
		go <= 1'b0;
		@(negedge core_clk_in);
		while (busy) @(negedge core_clk_in);
		@(negedge core_clk_in);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [7:0] bytes[64];
		logic [47:0] smp;
		int n;
		void'($urandom(3));
		repeat (2) @(negedge core_clk_in);
		reset_n_in = 1'b1;
		repeat (2) @(negedge core_clk_in);
		note(1, 0);
		note(2, 0);
		for (int i = 0; i < 25; i++) begin
			coef_sel_in = i[4:0];
			@(negedge core_clk_in);
			note(4, mfe_pkg::WRIST_COEF[i]);
		end
		// Fill the block, then read it whole, edit the copy and write it back whole
		for (int pass = 0; pass < 3; pass++) begin
			pulse(cfg_start_in);
			for (int i = 0; i <= 64; i++) begin
				pulse(cfg_rd_in);
				if (pass > 0)
					note(0, bytes[i % 64]);
			end
			if (pass < 2) begin
				pulse(cfg_start_in);
				for (int i = 0; i < 64; i++) begin
					bytes[i] = (pass == 0) ? 8'($urandom) : bytes[i] ^ 8'($urandom);
					cfg_wdata_in = bytes[i];
					pulse(cfg_wr_in);
				end
			end
		end
		count_en_in = 1'b1;
		detect_en_in = 1'b1;
		activity_en_in = 1'b1;
		n = $urandom_range(20, 5);
		walk(n[7:0]);
		note(1, n);
		note(2, 1);
		pulse(status_clr_in);
		for (int i = 0; i < 4; i++) begin
			ev = 4'h1 << i;
			@(negedge core_clk_in);
			ev = 4'h0;
			@(negedge core_clk_in);
			note(2, 2 << i);
			pulse(status_clr_in);
		end
		// Activity change must stay silent with activity recognition off
		activity_en_in = 1'b0;
		ev = 4'h1;
		@(negedge core_clk_in);
		ev = 4'h0;
		note(2, 0);
		activity_en_in = 1'b1;
		count_en_in = 1'b0;
		pulse(clear_req_in);
		note(1, n);
		count_en_in = 1'b1;
		pulse(clear_req_in);
		note(1, 0);
		thresh_in = 10'h001;
		walk(8'd19);
		note(2, 0);
		walk(8'd1);
		note(1, 20);
		note(2, 1);
		pulse(status_clr_in);
		{count_en_in, detect_en_in, activity_en_in} = 3'b000;
		coef_sel_in = 5'h00;
		coef_in = 16'h0132;
		pulse(coef_wr_in);
		note(4, mfe_pkg::WRIST_COEF[0]);
		{count_en_in, detect_en_in, activity_en_in} = 3'b111;
		repeat (2) @(negedge core_clk_in);
		note(4, 16'h0132);
		smp = 48'({$urandom, $urandom});
		sample_in = smp;
		remap_in = 6'h21;
		sample_valid_in = 1'b1;
		repeat (14) @(negedge core_clk_in);
		note(6, smp);
		note(5, {smp[47:32], smp[15:0], smp[31:16]});
		// Invert the new x and z axes, raw copy must not change
		remap_sign_in = 3'h5;
		repeat (2) @(negedge core_clk_in);
		note(5, {16'(-smp[47:32]), smp[15:0], 16'(-smp[31:16])});
		note(6, smp);
		sample_valid_in = 1'b0;
		cont_mode_in = 1'b0;
		tap_en_in = 1'b1;
		for (int i = 0; i < 3; i++) begin
			odr_hz_in = 12'h190 >> (2 * i);
			repeat (2) @(negedge core_clk_in);
			note(3, i + (i != 0));
		end
		pulse(fatal_in);
		walk(8'd3);
		note(2, 8'h80);
		note(1, 20);
		// Host reinitialises after the fatal stop; counting starts afresh
		reset_n_in = 1'b0;
		repeat (2) @(negedge core_clk_in);
		reset_n_in = 1'b1;
		repeat (2) @(negedge core_clk_in);
		note(2, 0);
		walk(8'd2);
		note(1, 2);
		stop_test();
	end
endmodule
`default_nettype wire
